// File: issr_pkg.sv
// issr_pkg: constants, types and field layout of the machine state word and save registers
// assumes bit 0 is the most significant bit, so vectors are declared [0:31]
// ************************************************************
// Summary of operation
// - software writes and reads whole state word
// - atomic set or clear of external enable
// - wait bit holds until interrupt, reset, debug, state word write or return
// - critical enable gates critical and watchdog
// - external enable gates external, decrementer, interval timer
// - user mode bit refuses privileged instructions
// - float available bit refuses float instructions
// - machine check enable gates machine checks
// - two float bits select exception mode
// - debug wait enable bit drives debug wait
// - debug enable bit gates debug interrupts
// - instruction space bit selects fetch space
// - data space bit selects data space
// - non-critical entry saves return, return resumes
// - return address word aligned, low bits reserved
// - non-critical entry copies state, return restores
// - return may restore reserved state bits
// - critical entry saves return, return resumes
// - critical return address word aligned
// - save registers writable and readable by software
// - interrupt entry clears listed state bits
// - critical entry copies state, return restores
// ************************************************************
package issr_pkg;

    // ************************************************************
    // state word bit positions
    // ************************************************************
    localparam int P_WAIT = 13;
    localparam int P_CEN = 14;
    localparam int P_XEN = 16;
    localparam int P_USR = 17;
    localparam int P_FPA = 18;
    localparam int P_MCE = 19;
    localparam int P_FXA = 20;
    localparam int P_DBW = 21;
    localparam int P_DBE = 22;
    localparam int P_FXB = 23;
    localparam int P_ISP = 26;
    localparam int P_DSP = 27;

    localparam logic [0:31] BIT0 = 32'h8000_0000;
    localparam logic [0:31] M_WAIT = BIT0 >> P_WAIT;
    localparam logic [0:31] M_CEN = BIT0 >> P_CEN;
    localparam logic [0:31] M_XEN = BIT0 >> P_XEN;
    localparam logic [0:31] M_USR = BIT0 >> P_USR;
    localparam logic [0:31] M_FPA = BIT0 >> P_FPA;
    localparam logic [0:31] M_MCE = BIT0 >> P_MCE;
    localparam logic [0:31] M_FXA = BIT0 >> P_FXA;
    localparam logic [0:31] M_DBW = BIT0 >> P_DBW;
    localparam logic [0:31] M_DBE = BIT0 >> P_DBE;
    localparam logic [0:31] M_FXB = BIT0 >> P_FXB;
    localparam logic [0:31] M_ISP = BIT0 >> P_ISP;
    localparam logic [0:31] M_DSP = BIT0 >> P_DSP;

    // implemented bits; everything else is reserved
    localparam logic [0:31] MSW_IMPL = M_WAIT | M_CEN | M_XEN | M_USR | M_FPA | M_MCE | M_FXA | M_DBW | M_DBE | M_FXB
                                     | M_ISP | M_DSP;
    // cleared by every interrupt class
    localparam logic [0:31] CLR_ALL = M_WAIT | M_XEN | M_USR | M_FPA | M_FXA | M_DBW | M_FXB | M_ISP | M_DSP;
    localparam logic [0:31] CLR_CRIT = M_CEN | M_DBE;
    localparam logic [0:31] CLR_MCHK = M_MCE;
    // return address keeps bits 0:29
    localparam logic [0:31] ADDR_MASK = 32'hffff_fffc;
    localparam logic [0:31] RESET_WORD = 32'h0000_0000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_MT_MSW = 4'h1,
        CMD_MF_MSW = 4'h2,
        CMD_WR_XEN = 4'h3,
        CMD_WR_XEN_IMM = 4'h4,
        CMD_MT_SPR = 4'h5,
        CMD_MF_SPR = 4'h6,
        CMD_RET = 4'h7,
        CMD_RET_CRIT = 4'h8
    } issr_cmd_t;

    typedef enum logic [1:0] {
        SPR_SAVE_ADDR = 2'h0,
        SPR_SAVE_COPY = 2'h1,
        SPR_CRIT_ADDR = 2'h2,
        SPR_CRIT_COPY = 2'h3
    } issr_spr_t;

    typedef enum logic [1:0] {
        CLS_NONCRIT = 2'h0,
        CLS_CRIT = 2'h1,
        CLS_MCHK = 2'h2
    } issr_cls_t;

    typedef enum logic [1:0] {
        FE_IGNORE = 2'h0,
        FE_IMP_NONREC = 2'h1,
        FE_IMP_REC = 2'h2,
        FE_PRECISE = 2'h3
    } issr_fe_t;

    typedef struct packed {
        logic valid;
        issr_cmd_t cmd;
        issr_spr_t spr;
        logic [0:31] wdata;
        logic imm;
    } issr_op_t;

    typedef struct packed {
        logic take;
        issr_cls_t cls;
        logic [0:31] addr;
    } issr_int_t;

    typedef struct packed {
        logic crit_in;
        logic wdog;
        logic ext_in;
        logic decr;
        logic fit;
        logic mchk;
        logic dbg;
    } issr_irq_t;

endpackage

// File: issr_core.sv
// issr_core: machine state word, save/restore registers, entry and return sequencing
// assumes op, interrupt and request inputs come from logic on core_clk
`timescale 1ns/100ps
module issr_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic core_en,
    // instruction port
    input wire issr_pkg::issr_op_t op,
    output logic rd_valid,
    output logic [0:31] rd_data,
    output logic priv_fault,
    input wire logic fp_op_valid,
    output logic fp_unavail_fault,
    // interrupt entry and return
    input wire issr_pkg::issr_int_t int_in,
    output logic redirect_valid,
    output logic [0:31] redirect_addr,
    // debug tool
    input wire logic dbg_clear_wait,
    // raw requests and gated requests
    input wire issr_pkg::issr_irq_t irq_raw,
    output issr_pkg::issr_irq_t irq_ok,
    // state outputs
    output logic [0:31] machine_state_word,
    output logic [0:31] save_return_addr,
    output logic [0:31] save_state_copy,
    output logic [0:31] crit_return_addr,
    output logic [0:31] crit_state_copy,
    output logic wait_state,
    output logic user_mode_flag,
    output logic float_unit_avail,
    output issr_pkg::issr_fe_t fe_mode,
    output logic dbg_wait_enable,
    output logic instr_space_sel,
    output logic data_space_sel
);
    import issr_pkg::*;

    // ************************************************************
    // decode
    // ************************************************************
    // an interrupt entry wins over an instruction in the same cycle; the instruction is dropped
    wire logic take = int_in.take;
    wire logic op_live = op.valid && !take && (op.cmd != CMD_NOP);
    wire logic op_ok = op_live && !machine_state_word[P_USR];
    wire logic op_refused = op_live && machine_state_word[P_USR];
    wire logic do_mt_msw = op_ok && (op.cmd == CMD_MT_MSW);
    wire logic do_wr_xen = op_ok && (op.cmd == CMD_WR_XEN);
    wire logic do_wr_xen_imm = op_ok && (op.cmd == CMD_WR_XEN_IMM);
    wire logic do_mt_spr = op_ok && (op.cmd == CMD_MT_SPR);
    wire logic do_ret = op_ok && (op.cmd == CMD_RET);
    wire logic do_ret_crit = op_ok && (op.cmd == CMD_RET_CRIT);
    wire logic do_read = op_ok && ((op.cmd == CMD_MF_MSW) || (op.cmd == CMD_MF_SPR));
    wire logic take_nc = take && (int_in.cls == CLS_NONCRIT);
    wire logic take_cr = take && (int_in.cls == CLS_CRIT);
    wire logic take_mc = take && (int_in.cls == CLS_MCHK);

    // ************************************************************
    // next state word
    // ************************************************************
    wire logic [0:31] clr_mask = CLR_ALL | (take_cr ? CLR_CRIT : RESET_WORD)
                               | (take_mc ? CLR_MCHK : RESET_WORD);
    wire logic new_xen = do_wr_xen ? op.wdata[P_XEN] : op.imm;
    wire logic [0:31] xen_word = (machine_state_word & ~M_XEN) | (new_xen ? M_XEN : RESET_WORD);
    wire logic [0:31] base_msw = take ? (machine_state_word & ~clr_mask) :
                                 do_mt_msw ? (op.wdata & MSW_IMPL) :
                                 (do_wr_xen || do_wr_xen_imm) ? xen_word :
                                 do_ret ? save_state_copy :
                                 do_ret_crit ? crit_state_copy :
                                 machine_state_word;
    // the debug tool only ever clears the wait bit; otherwise it holds until entry, reset, a state word write or a return
    wire logic [0:31] next_msw = base_msw & ~(dbg_clear_wait ? M_WAIT : RESET_WORD);
    wire logic [1:0] next_fe_bits = {next_msw[P_FXA], next_msw[P_FXB]};
    wire issr_fe_t next_fe_mode = (next_fe_bits == 2'h0) ? FE_IGNORE :
                                  (next_fe_bits == 2'h1) ? FE_IMP_NONREC :
                                  (next_fe_bits == 2'h2) ? FE_IMP_REC : FE_PRECISE;

    // ************************************************************
    // next save registers
    // ************************************************************
    wire logic [0:31] wr_addr = op.wdata & ADDR_MASK;
    wire logic [0:31] int_addr = int_in.addr & ADDR_MASK;
    wire logic [0:31] next_save_addr = take_nc ? int_addr :
                                       (do_mt_spr && op.spr == SPR_SAVE_ADDR) ? wr_addr :
                                       save_return_addr;
    wire logic [0:31] next_save_copy = take_nc ? machine_state_word :
                                       (do_mt_spr && op.spr == SPR_SAVE_COPY) ? op.wdata :
                                       save_state_copy;
    wire logic [0:31] next_crit_addr = take_cr ? int_addr :
                                       (do_mt_spr && op.spr == SPR_CRIT_ADDR) ? wr_addr :
                                       crit_return_addr;
    wire logic [0:31] next_crit_copy = take_cr ? machine_state_word :
                                       (do_mt_spr && op.spr == SPR_CRIT_COPY) ? op.wdata :
                                       crit_state_copy;

    // ************************************************************
    // read, redirect and gating
    // ************************************************************
    wire logic [0:31] spr_rd = (op.spr == SPR_SAVE_ADDR) ? save_return_addr :
                               (op.spr == SPR_SAVE_COPY) ? save_state_copy :
                               (op.spr == SPR_CRIT_ADDR) ? crit_return_addr : crit_state_copy;
    wire logic [0:31] next_rd_data = (op.cmd == CMD_MF_MSW) ? machine_state_word : spr_rd;
    wire logic [0:31] next_redirect = do_ret_crit ? crit_return_addr : save_return_addr;
    wire logic ce = machine_state_word[P_CEN];
    wire logic xen = machine_state_word[P_XEN];
    wire issr_irq_t next_irq_ok = '{
        crit_in: irq_raw.crit_in && ce,
        wdog: irq_raw.wdog && ce,
        ext_in: irq_raw.ext_in && xen,
        decr: irq_raw.decr && xen,
        fit: irq_raw.fit && xen,
        mchk: irq_raw.mchk && machine_state_word[P_MCE],
        dbg: irq_raw.dbg && machine_state_word[P_DBE]
    };

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            machine_state_word <= RESET_WORD;
            fe_mode <= FE_IGNORE;
        end else if (core_en) begin
            machine_state_word <= next_msw;
            fe_mode <= next_fe_mode;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            save_return_addr <= RESET_WORD;
            save_state_copy <= RESET_WORD;
            crit_return_addr <= RESET_WORD;
            crit_state_copy <= RESET_WORD;
        end else if (core_en) begin
            save_return_addr <= next_save_addr;
            save_state_copy <= next_save_copy;
            crit_return_addr <= next_crit_addr;
            crit_state_copy <= next_crit_copy;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            rd_data <= RESET_WORD;
            priv_fault <= 1'b0;
            fp_unavail_fault <= 1'b0;
            redirect_valid <= 1'b0;
            redirect_addr <= RESET_WORD;
            irq_ok <= '0;
        end else if (core_en) begin
            rd_valid <= do_read;
            rd_data <= do_read ? next_rd_data : RESET_WORD;
            priv_fault <= op_refused;
            fp_unavail_fault <= fp_op_valid && !machine_state_word[P_FPA];
            redirect_valid <= do_ret || do_ret_crit;
            redirect_addr <= next_redirect;
            irq_ok <= next_irq_ok;
        end
    end

    // single bits are slices of the state word flop
    assign wait_state = machine_state_word[P_WAIT];
    assign user_mode_flag = machine_state_word[P_USR];
    assign float_unit_avail = machine_state_word[P_FPA];
    assign dbg_wait_enable = machine_state_word[P_DBW];
    assign instr_space_sel = machine_state_word[P_ISP];
    assign data_space_sel = machine_state_word[P_DSP];

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_ret_req;
        core_en && do_ret && !dbg_clear_wait;
    endsequence
    sequence s_cret_req;
        core_en && do_ret_crit && !dbg_clear_wait;
    endsequence
    sequence s_cret_done;
        redirect_valid && (redirect_addr == $past(crit_return_addr))
        && (machine_state_word == $past(crit_state_copy));
    endsequence
    sequence s_ret_done;
        redirect_valid && (redirect_addr == $past(save_return_addr)) && (machine_state_word == $past(save_state_copy));
    endsequence

    property p_ret;
        @(posedge core_clk) disable iff (!rstn) s_ret_req |=> s_ret_done;
    endproperty
    a_ret: assert property (p_ret) else $error("return did not restore state and address");

    property p_mt_msw;
        @(posedge core_clk) disable iff (!rstn)
            core_en && do_mt_msw && !dbg_clear_wait |=> machine_state_word == ($past(op.wdata) & MSW_IMPL);
    endproperty
    a_mt_msw: assert property (p_mt_msw) else $error("state word write lost or reserved bits kept");

    property p_xen_only;
        @(posedge core_clk) disable iff (!rstn)
            core_en && (do_wr_xen || do_wr_xen_imm) && !dbg_clear_wait
            |=> (machine_state_word & ~M_XEN) == ($past(machine_state_word) & ~M_XEN);
    endproperty
    a_xen_only: assert property (p_xen_only) else $error("enable update disturbed other bits");

    property p_wait_hold;
        @(posedge core_clk) disable iff (!rstn)
            core_en && wait_state && !take && !dbg_clear_wait && !op_ok |=> wait_state;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait state left without cause");

    property p_ext_gate;
        @(posedge core_clk) disable iff (!rstn)
            core_en |=> irq_ok.decr == ($past(irq_raw.decr) && $past(xen))
            && irq_ok.ext_in == ($past(irq_raw.ext_in) && $past(xen))
            && irq_ok.fit == ($past(irq_raw.fit) && $past(xen));
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("external class gating wrong");

    property p_priv;
        @(posedge core_clk) disable iff (!rstn)
            core_en && op_refused && !dbg_clear_wait |=> priv_fault && $stable(machine_state_word) && !rd_valid;
    endproperty
    a_priv: assert property (p_priv) else $error("privileged op ran in user mode");

    property p_fe_mode;
        @(posedge core_clk) disable iff (!rstn)
            fe_mode == issr_fe_t'({machine_state_word[P_FXA], machine_state_word[P_FXB]});
    endproperty
    a_fe_mode: assert property (p_fe_mode) else $error("float exception mode mismatch");

    property p_crit_entry;
        @(posedge core_clk) disable iff (!rstn)
            core_en && take_cr |=> crit_state_copy == $past(machine_state_word)
            && crit_return_addr == ($past(int_in.addr) & ADDR_MASK)
            && (machine_state_word & (CLR_ALL | CLR_CRIT)) == RESET_WORD;
    endproperty
    a_crit_entry: assert property (p_crit_entry) else $error("critical entry save or clear wrong");

    property p_nc_entry;
        @(posedge core_clk) disable iff (!rstn)
            core_en && take_nc |=> save_state_copy == $past(machine_state_word)
            && (machine_state_word & M_CEN) == ($past(machine_state_word) & M_CEN)
            && (machine_state_word & CLR_ALL) == RESET_WORD;
    endproperty
    a_nc_entry: assert property (p_nc_entry) else $error("non-critical entry save or clear wrong");

    property p_align;
        @(posedge core_clk) disable iff (!rstn)
            save_return_addr[30:31] == 2'h0 && crit_return_addr[30:31] == 2'h0;
    endproperty
    a_align: assert property (p_align) else $error("return address not word aligned");

    property p_ret_crit;
        @(posedge core_clk) disable iff (!rstn) s_cret_req |=> s_cret_done;
    endproperty
    a_ret_crit: assert property (p_ret_crit) else $error("critical return wrong");

    property p_crit_gate;
        @(posedge core_clk) disable iff (!rstn)
            core_en |=> irq_ok.crit_in == ($past(irq_raw.crit_in) && $past(ce))
            && irq_ok.wdog == ($past(irq_raw.wdog) && $past(ce));
    endproperty
    a_crit_gate: assert property (p_crit_gate) else $error("critical gating wrong");

    property p_mchk_gate;
        @(posedge core_clk) disable iff (!rstn)
            core_en |=> irq_ok.mchk == ($past(irq_raw.mchk) && $past(machine_state_word[P_MCE]));
    endproperty
    a_mchk_gate: assert property (p_mchk_gate) else $error("machine check gating wrong");

    property p_dbg_gate;
        @(posedge core_clk) disable iff (!rstn)
            core_en |=> irq_ok.dbg == ($past(irq_raw.dbg) && $past(machine_state_word[P_DBE]));
    endproperty
    a_dbg_gate: assert property (p_dbg_gate) else $error("debug gating wrong");

    property p_fp_fault;
        @(posedge core_clk) disable iff (!rstn)
            core_en |=> fp_unavail_fault == ($past(fp_op_valid) && !$past(float_unit_avail));
    endproperty
    a_fp_fault: assert property (p_fp_fault) else $error("float refusal wrong");

    property p_nc_addr;
        @(posedge core_clk) disable iff (!rstn)
            core_en && take_nc |=> save_return_addr == ($past(int_in.addr) & ADDR_MASK);
    endproperty
    a_nc_addr: assert property (p_nc_addr) else $error("return address not saved");

    property p_mchk_entry;
        @(posedge core_clk) disable iff (!rstn)
            core_en && take_mc |=> (machine_state_word & (CLR_ALL | CLR_MCHK)) == RESET_WORD
            && $stable(save_state_copy);
    endproperty
    a_mchk_entry: assert property (p_mchk_entry) else $error("machine check entry wrong");

    property p_spr_wr;
        @(posedge core_clk) disable iff (!rstn)
            core_en && do_mt_spr && op.spr == SPR_SAVE_COPY |=> save_state_copy == $past(op.wdata);
    endproperty
    a_spr_wr: assert property (p_spr_wr) else $error("state copy write lost");

    property p_read;
        @(posedge core_clk) disable iff (!rstn)
            core_en && do_read && op.cmd == CMD_MF_MSW |=> rd_valid && rd_data == $past(machine_state_word);
    endproperty
    a_read: assert property (p_read) else $error("state word read wrong");

    // a low enable must hold the state word, the saved state copy and the rd_valid output
    property p_freeze;
        @(posedge core_clk) disable iff (!rstn)
            !core_en |=> $stable(machine_state_word) && $stable(save_state_copy) && $stable(rd_valid);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while enable low");

endmodule

// File: tb.sv
// tb: self-checking bench for issr_core, driving the instruction, interrupt and request ports
// assumes issr_pkg is compiled first; all stimulus but irq_raw moves at the rising edge of core_clk, irq_raw 1 ns after it
`timescale 1ns/100ps
module tb;
    import issr_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic core_en = 1'b1;
    logic fp_op_valid = 1'b0;
    logic dbg_clear_wait = 1'b0;
    issr_op_t op = '0;
    issr_int_t int_in = '0;
    issr_irq_t irq_raw = '0;
    issr_irq_t irq_ok;
    issr_fe_t fe_mode;
    logic rd_valid, priv_fault, fp_unavail_fault, redirect_valid, wait_state, user_mode_flag;
    logic float_unit_avail, dbg_wait_enable, instr_space_sel, data_space_sel;
    logic [0:31] rd_data, redirect_addr, machine_state_word, save_return_addr, save_state_copy;
    logic [0:31] crit_return_addr, crit_state_copy, w;
    int error_cnt = 0;
    int n_tests = 0;
    logic [0:31] en_tab [4] = '{M_CEN, M_XEN, M_MCE, M_DBE};
    logic [6:0] ok_tab [4] = '{7'h60, 7'h1c, 7'h02, 7'h01};

    always #5 core_clk = ~core_clk;

    issr_core DUT (.core_clk(core_clk), .rstn(rstn), .core_en(core_en), .op(op), .rd_valid(rd_valid),
        .rd_data(rd_data), .priv_fault(priv_fault), .fp_op_valid(fp_op_valid),
        .fp_unavail_fault(fp_unavail_fault), .int_in(int_in), .redirect_valid(redirect_valid),
        .redirect_addr(redirect_addr), .dbg_clear_wait(dbg_clear_wait), .irq_raw(irq_raw), .irq_ok(irq_ok),
        .machine_state_word(machine_state_word), .save_return_addr(save_return_addr),
        .save_state_copy(save_state_copy), .crit_return_addr(crit_return_addr),
        .crit_state_copy(crit_state_copy), .wait_state(wait_state), .user_mode_flag(user_mode_flag),
        .float_unit_avail(float_unit_avail), .fe_mode(fe_mode), .dbg_wait_enable(dbg_wait_enable),
        .instr_space_sel(instr_space_sel), .data_space_sel(data_space_sel));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string name, input logic [0:31] exp, input logic [0:31] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one op, then sample just after the edge that took it
    task automatic do_op(input issr_cmd_t c, input issr_spr_t s, input logic [0:31] d, input logic i);
        @(posedge core_clk);
        op <= '{valid: 1'b1, cmd: c, spr: s, wdata: d, imm: i};
        @(posedge core_clk);
        op <= '0;
        #1;
    endtask

    task automatic rd_chk(input issr_cmd_t c, input issr_spr_t s, input string name, input logic [0:31] exp);
        do_op(c, s, 32'h0000_0000, 1'b0);
        chk("rd_valid", 32'h0000_0001, {31'h0, rd_valid});
        chk(name, exp, rd_data);
    endtask

    task automatic intr(input issr_cls_t cls, input logic [0:31] addr);
        @(posedge core_clk);
        int_in <= '{take: 1'b1, cls: cls, addr: addr};
        @(posedge core_clk);
        int_in <= '0;
        #1;
    endtask

    task automatic fp_try(input logic exp);
        @(posedge core_clk);
        fp_op_valid <= 1'b1;
        @(posedge core_clk);
        fp_op_valid <= 1'b0;
        #1;
        chk("fp_unavail_fault", {31'h0, exp}, {31'h0, fp_unavail_fault});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        #100000;
        error_cnt++;
        $display("Error run_time expected finish seen timeout");
        tally_and_finish;
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("machine_state_word", 32'h0000_0000, machine_state_word);
        chk("save_copy_or_addr", 32'h0000_0000, save_return_addr | save_state_copy | crit_return_addr);
        $display("test reset done");
        // reserved bits must read back zero; the user bit is kept low so later ops still run
        w = MSW_IMPL & ~M_USR;
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, 32'hffff_ffff & ~M_USR, 1'b0);
        rd_chk(CMD_MF_MSW, SPR_SAVE_ADDR, "msw_read", w);
        chk("wait_state", 32'h1, {31'h0, wait_state});
        chk("float_unit_avail", 32'h1, {31'h0, float_unit_avail});
        chk("dbg_wait_enable", 32'h1, {31'h0, dbg_wait_enable});
        chk("space_sel", 32'h3, {30'h0, instr_space_sel, data_space_sel});
        $display("test state_word done");
        irq_raw <= 7'h7f;
        for (int k = 0; k < 4; k++) begin
            do_op(CMD_MT_MSW, SPR_SAVE_ADDR, en_tab[k], 1'b0);
            @(posedge core_clk);
            #1;
            chk("irq_ok", {25'h0, ok_tab[k]}, {25'h0, irq_ok});
        end
        irq_raw <= '0;
        $display("test gating done");
        for (int k = 0; k < 4; k++) begin
            do_op(CMD_MT_MSW, SPR_SAVE_ADDR, (k[1] ? M_FXA : 32'h0) | (k[0] ? M_FXB : 32'h0), 1'b0);
            chk("fe_mode", {30'h0, 2'(k)}, {30'h0, fe_mode});
        end
        $display("test fe_mode done");
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, M_CEN | M_FPA, 1'b0);
        do_op(CMD_WR_XEN, SPR_SAVE_ADDR, M_XEN, 1'b0);
        chk("msw_wr_xen", M_CEN | M_FPA | M_XEN, machine_state_word);
        do_op(CMD_WR_XEN_IMM, SPR_SAVE_ADDR, 32'hffff_ffff, 1'b0);
        chk("msw_wr_xen_imm", M_CEN | M_FPA, machine_state_word);
        do_op(CMD_WR_XEN_IMM, SPR_SAVE_ADDR, 32'h0, 1'b1);
        chk("msw_wr_xen_set", M_CEN | M_FPA | M_XEN, machine_state_word);
        do_op(CMD_WR_XEN, SPR_SAVE_ADDR, ~M_XEN, 1'b0);
        chk("msw_wr_xen_clr", M_CEN | M_FPA, machine_state_word);
        fp_try(1'b0);
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, 32'h0, 1'b0);
        fp_try(1'b1);
        $display("test ext_enable_fp done");
        for (int k = 0; k < 4; k++) begin
            do_op(CMD_MT_SPR, issr_spr_t'(k), 32'hffff_ffff, 1'b0);
            rd_chk(CMD_MF_SPR, issr_spr_t'(k), "spr_read", k[0] ? 32'hffff_ffff : ADDR_MASK);
        end
        $display("test spr done");
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, M_WAIT, 1'b0);
        @(posedge core_clk);
        dbg_clear_wait <= 1'b1;
        @(posedge core_clk);
        dbg_clear_wait <= 1'b0;
        #1;
        chk("wait_state_dbg", 32'h0, {31'h0, wait_state});
        w = MSW_IMPL & ~M_USR;
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, w, 1'b0);
        intr(CLS_NONCRIT, 32'h1234_5677);
        chk("save_return_addr", 32'h1234_5674, save_return_addr);
        chk("save_state_copy", w, save_state_copy);
        chk("msw_noncrit", w & ~CLR_ALL, machine_state_word);
        do_op(CMD_RET, SPR_SAVE_ADDR, 32'h0, 1'b0);
        chk("redirect", 32'h1234_5675, {redirect_addr[0:30], redirect_valid});
        chk("msw_ret", w, machine_state_word);
        intr(CLS_CRIT, 32'h8765_4323);
        chk("crit_return_addr", 32'h8765_4320, crit_return_addr);
        chk("crit_state_copy", w, crit_state_copy);
        chk("msw_crit", w & ~(CLR_ALL | CLR_CRIT), machine_state_word);
        do_op(CMD_RET_CRIT, SPR_SAVE_ADDR, 32'h0, 1'b0);
        chk("redirect_crit", 32'h8765_4321, {redirect_addr[0:30], redirect_valid});
        chk("msw_ret_crit", w, machine_state_word);
        intr(CLS_MCHK, 32'h0000_1000);
        chk("msw_mchk", w & ~(CLR_ALL | CLR_MCHK), machine_state_word);
        chk("crit_addr_kept", 32'h8765_4320, crit_return_addr);
        $display("test entry_return done");
        // once in user mode only an interrupt or reset can bring the core back
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, M_USR | M_XEN, 1'b0);
        chk("user_mode_flag", 32'h1, {31'h0, user_mode_flag});
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, 32'h0, 1'b0);
        chk("priv_fault", 32'h1, {31'h0, priv_fault});
        chk("msw_user", M_USR | M_XEN, machine_state_word);
        intr(CLS_NONCRIT, 32'h0000_2000);
        chk("msw_after_user", 32'h0, machine_state_word);
        do_op(CMD_MT_SPR, SPR_SAVE_COPY, 32'h8000_0001, 1'b0);
        do_op(CMD_RET, SPR_SAVE_ADDR, 32'h0, 1'b0);
        chk("msw_reserved_restore", 32'h8000_0001, machine_state_word);
        $display("test privilege_reserved done");
        // an op offered while the enable is low must be dropped, then reset clears it all
        @(posedge core_clk);
        core_en <= 1'b0;
        do_op(CMD_MT_MSW, SPR_SAVE_ADDR, M_CEN, 1'b0);
        chk("msw_frozen", 32'h8000_0001, machine_state_word);
        @(posedge core_clk);
        core_en <= 1'b1;
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("msw_after_reset", 32'h0, machine_state_word | save_state_copy);
        $display("test freeze_reset done");
        tally_and_finish;
    end
endmodule
